// ---- hdl/psc_hist_mem.sv ----
// Sample history memory, read-before-write with registered read data
`timescale 1ns/1ps
module psc_hist_mem #(
  parameter int DEPTH = 4,
  parameter int W     = 128,
  parameter int AW    = 2
) (
  input  wire logic          clk_i,
  input  wire logic          reset_i,
  input  wire logic          ce_i,
  input  wire logic          we_i,
  input  wire logic [AW-1:0] addr_i,
  input  wire logic [W-1:0]  wdata_i,
  output logic [W-1:0]       rdata_o
);
  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [W-1:0]            rd;
  } psc_mem_st_t;

  psc_mem_st_t s_ff;
  psc_mem_st_t nxt_s;

  // The old word leaves before the new one lands at the same slot
  always_comb begin
    nxt_s = s_ff;
    if (we_i) begin
      nxt_s.rd          = s_ff.mem[addr_i];
      nxt_s.mem[addr_i] = wdata_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      s_ff <= '0;
    end else if (ce_i) begin
      s_ff <= nxt_s;
    end
  end

  assign rdata_o = s_ff.rd;
endmodule : psc_hist_mem

// ---- hdl/psc_pkg.sv ----
// Constants and types shared by the programmable stage comparator
// Operation
// - One to four selectable measurements, compared separately
// - Scale each measurement by multiplier, show it
// - Show ratio of each magnitude to level
// - Hysteresis zero to fifty percent, default three
// - Signed pick-up level, default one hundredth
// - Operate delay in 5 ms steps before trip
// - Release delay in 5 ms steps after pickup
// - Eight comparator modes, greater-than by default
// - Greater-than: signed value above level
// - Absolute greater-than: magnitude above level
// - Less-than, suppressed below blocking limit
// - Absolute less-than, suppressed below blocking limit
// - Signed relative change over 20 ms
// - Absolute relative change over 20 ms
// - Signed value change over 20 ms
// - Absolute value change over 20 ms
// - Condition is normal, start, trip or blocked
// - Show time remaining until trip
// - Show expected operating time
// - Show behaviour mode only when enabled
// - Own level and hysteresis per comparison
// - Block at pickup gives blocked, start releases
package psc_pkg;
  localparam int CLK_NS    = 4;
  localparam int STEP_MS   = 5;
  localparam int STEP_NS   = STEP_MS * 1_000_000;
  localparam int STEP_CYC  = STEP_NS / CLK_NS;
  localparam int WIN_MS    = 20;
  localparam int WIN_STEPS = WIN_MS / STEP_MS;
  localparam int NCH       = 4;
  localparam int DW        = 32;
  localparam int RW        = 48;
  localparam int TW        = 19;
  localparam int MULT_FRAC = 16;
  localparam int UNIT      = 10_000;
  localparam int PCT_DEN   = 1_000_000;
  localparam int OP_DLY_MS  = 40;
  localparam int REL_DLY_MS = 60;

  typedef logic signed [DW-1:0] psc_word_t;
  typedef logic signed [RW-1:0] psc_ratio_t;

  localparam psc_word_t   MULT_RST    = psc_word_t'(1) <<< MULT_FRAC;
  localparam psc_word_t   LEVEL_RST   = 32'h0000_0064;
  localparam logic [DW-1:0] HYST_RST  = 32'h0000_7530;
  localparam psc_word_t   BLK_RST     = 32'h8000_0000;
  localparam logic [TW-1:0] OP_DLY_RST  = TW'(OP_DLY_MS / STEP_MS);
  localparam logic [TW-1:0] REL_DLY_RST = TW'(REL_DLY_MS / STEP_MS);

  typedef enum logic [2:0] {
    CMP_OVER, CMP_OVER_ABS, CMP_UNDER, CMP_UNDER_ABS,
    CMP_DREL, CMP_DREL_ABS, CMP_DVAL, CMP_DVAL_ABS
  } psc_cmp_t;
  typedef enum logic [1:0] {COND_NORMAL, COND_START, COND_TRIP, COND_BLOCKED} psc_cond_t;
  typedef enum logic [2:0] {BEH_ON, BEH_BLOCKED, BEH_TEST, BEH_TEST_OFF, BEH_OFF} psc_beh_t;
endpackage : psc_pkg

// ---- hdl/psc_stage.sv ----
// Programmable protection stage: scaling, comparators, timers and display values
`timescale 1ns/1ps
module psc_stage
  import psc_pkg::*;
#(
  parameter int TICK_CYC = STEP_CYC
) (
  input  wire logic                   clk_i,
  input  wire logic                   reset_i,
  input  wire logic                   ce_i,
  input  wire psc_word_t [NCH-1:0]    meas_i,
  input  wire logic                   cfg_we_i,
  input  wire logic [NCH-1:0]         cfg_sel_i,
  input  wire psc_word_t [NCH-1:0]    cfg_mult_i,
  input  wire psc_cmp_t [NCH-1:0]     cfg_mode_i,
  input  wire psc_word_t [NCH-1:0]    cfg_level_i,
  input  wire logic [NCH-1:0][DW-1:0] cfg_hyst_i,
  input  wire psc_word_t [NCH-1:0]    cfg_blk_lim_i,
  input  wire logic [TW-1:0]          cfg_op_dly_i,
  input  wire logic [TW-1:0]          cfg_rel_dly_i,
  input  wire logic                   block_i,
  input  wire psc_beh_t               beh_mode_i,
  input  wire logic                   indiv_mode_en_i,
  output psc_word_t [NCH-1:0]         scaled_o,
  output psc_ratio_t [NCH-1:0]        ratio_o,
  output logic [NCH-1:0]              cmp_o,
  output psc_cond_t                   cond_o,
  output logic                        start_o,
  output logic                        trip_o,
  output logic                        blocked_o,
  output logic [TW-1:0]               remain_o,
  output logic [TW-1:0]               expect_o,
  output psc_beh_t                    beh_o,
  output logic                        beh_vis_o
);
  localparam int CW  = $clog2(TICK_CYC + 1);
  localparam int AW  = $clog2(WIN_STEPS);
  localparam int HFW = $clog2(WIN_STEPS + 1);
  localparam int CHW = $clog2(NCH);
  localparam int DCW = $clog2(RW + 1);

  typedef struct packed {
    logic [CW-1:0]          tick_cnt;
    logic                   ph1;
    logic                   ph2;
    logic [AW-1:0]          wptr;
    logic [HFW-1:0]         fill;
    logic                   hist_ok;
    logic [NCH-1:0]         sel;
    psc_word_t [NCH-1:0]    mult;
    psc_word_t [NCH-1:0]    level;
    psc_word_t [NCH-1:0]    blk_lim;
    logic [NCH-1:0][DW-1:0] hyst;
    psc_cmp_t [NCH-1:0]     mode;
    logic [TW-1:0]          op_dly;
    logic [TW-1:0]          rel_dly;
    psc_word_t [NCH-1:0]    scaled;
    psc_ratio_t [NCH-1:0]   ratio;
    logic [NCH-1:0]         held;
    psc_cond_t              cond;
    logic                   start;
    logic                   trip;
    logic                   blocked;
    logic [TW-1:0]          op_cnt;
    logic [TW-1:0]          rel_cnt;
    logic [TW-1:0]          remain;
    psc_beh_t               beh;
    logic                   beh_vis;
    logic [CHW-1:0]         div_ch;
    logic [DCW-1:0]         div_cnt;
    logic                   div_busy;
    logic                   div_neg;
    logic [DW:0]            div_rem;
    logic [RW-1:0]          div_quo;
    logic [DW-1:0]          div_den;
  } psc_st_t;

  psc_st_t             s_ff;
  psc_st_t             nxt_s;
  psc_word_t [NCH-1:0] scaled_nxt;
  psc_word_t [NCH-1:0] hist_rd;
  logic [NCH-1:0]      cmp_nxt;
  logic                pick_w;
  logic                blk_w;

  function automatic logic [DW-1:0] abs_w(input psc_word_t x);
    return x[DW-1] ? DW'(-x) : DW'(x);
  endfunction : abs_w

  function automatic psc_st_t rst_state();
    psc_st_t r;
    r = '0;
    r.op_dly  = OP_DLY_RST;
    r.rel_dly = REL_DLY_RST;
    r.sel     = NCH'(1);
    for (int i = 0; i < NCH; i++) begin
      r.mult[i]    = MULT_RST;
      r.level[i]   = LEVEL_RST;
      r.hyst[i]    = HYST_RST;
      r.blk_lim[i] = BLK_RST;
      r.mode[i]    = CMP_OVER;
    end
    return r;
  endfunction : rst_state

  // One comparison; held selects the release threshold once picked up
  function automatic logic cmp_next(input psc_cmp_t m, input psc_word_t x,
                                    input psc_word_t old, input psc_word_t lvl,
                                    input logic [DW-1:0] hyst, input psc_word_t blk,
                                    input logic held, input logic hist_ok);
    logic signed [63:0] xv;
    logic signed [63:0] lv;
    logic signed [63:0] band;
    logic signed [63:0] d;
    logic signed [63:0] thr;
    logic signed [63:0] lim;
    logic               r;
    xv   = 64'(x);
    lv   = 64'(lvl);
    band = (64'(abs_w(lvl)) * 64'(hyst)) / 64'(PCT_DEN);
    d    = xv - 64'(old);
    thr  = '0;
    lim  = '0;
    r    = 1'b0;
    unique case (m)
      CMP_OVER, CMP_OVER_ABS: begin
        if (m == CMP_OVER_ABS) begin
          xv = 64'(abs_w(x));
        end
        lim = held ? lv - band : lv;
        r   = xv > lim;
      end
      CMP_UNDER, CMP_UNDER_ABS: begin
        if (m == CMP_UNDER_ABS) begin
          xv = 64'(abs_w(x));
        end
        lim = held ? lv + band : lv;
        r   = (xv < lim) && (x >= blk);
      end
      CMP_DREL, CMP_DREL_ABS, CMP_DVAL, CMP_DVAL_ABS: begin
        if (m == CMP_DREL || m == CMP_DREL_ABS) begin
          thr = (64'(abs_w(old)) * 64'(abs_w(lvl))) / 64'(PCT_DEN);
        end else begin
          thr = 64'(abs_w(lvl));
        end
        // Direction of signed modes follows the sign of the level
        if (m == CMP_DREL_ABS || m == CMP_DVAL_ABS) begin
          d = (d < 0) ? -d : d;
        end else if (lvl < 0) begin
          d = -d;
        end
        lim = held ? thr - (thr * 64'(hyst)) / 64'(PCT_DEN) : thr;
        r   = hist_ok && (d > lim);
      end
    endcase
    return r;
  endfunction : cmp_next

  ////////////////////////////////////////////////////////////////////////////
  // Per channel scaling and comparison

  for (genvar g = 0; g < NCH; g++) begin : g_ch
    logic signed [63:0] prod;
    assign prod          = 64'(meas_i[g]) * 64'(s_ff.mult[g]);
    assign scaled_nxt[g] = prod[MULT_FRAC +: DW];
    assign cmp_nxt[g]    = cmp_next(s_ff.mode[g], s_ff.scaled[g], hist_rd[g],
                                    s_ff.level[g], s_ff.hyst[g], s_ff.blk_lim[g],
                                    s_ff.held[g], s_ff.hist_ok);
  end

  // Samples of the last 20 ms; the slot being overwritten is the oldest
  psc_hist_mem #(
    .DEPTH (WIN_STEPS),
    .W     (NCH * DW),
    .AW    (AW)
  ) u_hist (
    .clk_i   (clk_i),
    .reset_i (reset_i),
    .ce_i    (ce_i),
    .we_i    (s_ff.ph1),
    .addr_i  (s_ff.wptr),
    .wdata_i (s_ff.scaled),
    .rdata_o (hist_rd)
  );

  assign pick_w = |(cmp_nxt & s_ff.sel);
  assign blk_w  = block_i || (beh_mode_i == BEH_BLOCKED);

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    logic [DW:0]   rem_sh;
    logic [RW-1:0] num;
    nxt_s  = s_ff;
    rem_sh = '0;
    num    = '0;

    // Step cadence of 5 ms, then two pipeline phases
    nxt_s.tick_cnt = (s_ff.tick_cnt == '0) ? CW'(TICK_CYC - 1) : s_ff.tick_cnt - 1'b1;
    nxt_s.ph1      = (s_ff.tick_cnt == '0);
    nxt_s.ph2      = s_ff.ph1;

    // settings load with defaults from reset
    if (cfg_we_i) begin
      nxt_s.sel     = cfg_sel_i;
      nxt_s.mult    = cfg_mult_i;
      nxt_s.mode    = cfg_mode_i;
      nxt_s.level   = cfg_level_i;
      nxt_s.hyst    = cfg_hyst_i;
      nxt_s.blk_lim = cfg_blk_lim_i;
      nxt_s.op_dly  = cfg_op_dly_i;
      nxt_s.rel_dly = cfg_rel_dly_i;
    end

    if (s_ff.tick_cnt == '0) begin
      nxt_s.scaled = scaled_nxt;
    end

    // Delta modes stay quiet until a full window of samples exists
    if (s_ff.ph1) begin
      nxt_s.wptr    = s_ff.wptr + 1'b1;
      nxt_s.hist_ok = (s_ff.fill == HFW'(WIN_STEPS));
      if (s_ff.fill != HFW'(WIN_STEPS)) begin
        nxt_s.fill = s_ff.fill + 1'b1;
      end
    end

    // shared serial divider, channels in turn
    if (!s_ff.div_busy) begin
      num              = RW'(abs_w(s_ff.scaled[s_ff.div_ch])) * RW'(UNIT);
      nxt_s.div_quo    = num;
      nxt_s.div_rem    = '0;
      nxt_s.div_den    = abs_w(s_ff.level[s_ff.div_ch]);
      nxt_s.div_neg    = s_ff.scaled[s_ff.div_ch][DW-1] ^ s_ff.level[s_ff.div_ch][DW-1];
      nxt_s.div_cnt    = DCW'(RW);
      nxt_s.div_busy   = 1'b1;
    end else if (s_ff.div_cnt != '0) begin
      rem_sh = {s_ff.div_rem[DW-1:0], s_ff.div_quo[RW-1]};
      if (rem_sh >= {1'b0, s_ff.div_den}) begin
        nxt_s.div_rem = rem_sh - {1'b0, s_ff.div_den};
        nxt_s.div_quo = {s_ff.div_quo[RW-2:0], 1'b1};
      end else begin
        nxt_s.div_rem = rem_sh;
        nxt_s.div_quo = {s_ff.div_quo[RW-2:0], 1'b0};
      end
      nxt_s.div_cnt = s_ff.div_cnt - 1'b1;
    end else begin
      nxt_s.ratio[s_ff.div_ch] = s_ff.div_neg ? -psc_ratio_t'(s_ff.div_quo)
                                              : psc_ratio_t'(s_ff.div_quo);
      nxt_s.div_ch   = (s_ff.div_ch == CHW'(NCH - 1)) ? '0 : s_ff.div_ch + 1'b1;
      nxt_s.div_busy = 1'b0;
    end

    nxt_s.beh     = indiv_mode_en_i ? beh_mode_i : BEH_ON;
    nxt_s.beh_vis = indiv_mode_en_i;

    if (s_ff.ph2) begin
      nxt_s.held = cmp_nxt & s_ff.sel;
      if (beh_mode_i == BEH_OFF) begin
        nxt_s.held = '0;
        nxt_s.cond = COND_NORMAL;
      end else begin
        unique case (s_ff.cond)
          COND_NORMAL: begin
            if (pick_w) begin
              if (blk_w) begin
                nxt_s.cond = COND_BLOCKED;
              end else begin
                // A zero operate delay trips in the pick-up step itself
                nxt_s.cond    = (s_ff.op_dly == '0) ? COND_TRIP : COND_START;
                nxt_s.op_cnt  = s_ff.op_dly;
                nxt_s.rel_cnt = s_ff.rel_dly;
              end
            end
          end
          COND_BLOCKED: begin
            if (!pick_w) begin
              nxt_s.cond = COND_NORMAL;
            end else if (!blk_w) begin
              nxt_s.cond    = (s_ff.op_dly == '0) ? COND_TRIP : COND_START;
              nxt_s.op_cnt  = s_ff.op_dly;
              nxt_s.rel_cnt = s_ff.rel_dly;
            end
          end
          COND_START, COND_TRIP: begin
            if (pick_w && !blk_w) begin
              nxt_s.rel_cnt = s_ff.rel_dly;
              if (s_ff.cond == COND_START) begin
                // Trip in the last counted step, op_dly steps after start
                if (s_ff.op_cnt <= TW'(1'b1)) begin
                  nxt_s.cond   = COND_TRIP;
                  nxt_s.op_cnt = '0;
                end else begin
                  nxt_s.op_cnt = s_ff.op_cnt - 1'b1;
                end
              end
            // release delay, also on late block
            end else if (s_ff.rel_cnt == '0) begin
              nxt_s.cond = (pick_w && blk_w) ? COND_BLOCKED : COND_NORMAL;
            end else begin
              nxt_s.rel_cnt = s_ff.rel_cnt - 1'b1;
            end
          end
        endcase
      end
      // flags follow the condition; test-off keeps start and trip quiet
      nxt_s.start   = (nxt_s.cond == COND_START) && (beh_mode_i != BEH_TEST_OFF);
      nxt_s.trip    = (nxt_s.cond == COND_TRIP) && (beh_mode_i != BEH_TEST_OFF);
      nxt_s.blocked = (nxt_s.cond == COND_BLOCKED);
      nxt_s.remain  = (nxt_s.cond == COND_START) ? nxt_s.op_cnt : '0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      s_ff <= rst_state();
    end else if (ce_i) begin
      s_ff <= nxt_s;
    end
  end

  assign scaled_o  = s_ff.scaled;
  assign ratio_o   = s_ff.ratio;
  assign cmp_o     = s_ff.held;
  assign cond_o    = s_ff.cond;
  assign start_o   = s_ff.start;
  assign trip_o    = s_ff.trip;
  assign blocked_o = s_ff.blocked;
  assign remain_o  = s_ff.remain;
  assign expect_o  = s_ff.op_dly;
  assign beh_o     = s_ff.beh;
  assign beh_vis_o = s_ff.beh_vis;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);

  sequence s_eval_on;
    ce_i && s_ff.ph2 && (beh_mode_i != BEH_OFF);
  endsequence

  sequence s_over_ch0;
    s_ff.sel[0] && (s_ff.mode[0] == CMP_OVER) && (s_ff.scaled[0] > s_ff.level[0]);
  endsequence

  property p_trip_cond;
    trip_o |-> (cond_o == COND_TRIP) && !start_o && !blocked_o;
  endproperty
  a_trip_cond: assert property (p_trip_cond) else $error("trip without trip condition");

  property p_scale;
    (ce_i && s_ff.tick_cnt == '0)
      |=> scaled_o[0] == psc_word_t'((64'($past(meas_i[0])) * 64'($past(s_ff.mult[0])))
                                     >>> MULT_FRAC);
  endproperty
  a_scale: assert property (p_scale) else $error("scaled magnitude wrong");

  property p_op_trip;
    s_eval_on ##0 (s_ff.cond == COND_START && pick_w && !blk_w && s_ff.op_cnt <= TW'(1'b1))
      |=> cond_o == COND_TRIP;
  endproperty
  a_op_trip: assert property (p_op_trip) else $error("no trip at end of delay");

  property p_block;
    s_eval_on ##0 (s_ff.cond == COND_NORMAL && pick_w && blk_w)
      |=> blocked_o && !start_o && (cond_o == COND_BLOCKED);
  endproperty
  a_block: assert property (p_block) else $error("blocked pickup did not block");

  property p_release;
    ($past(s_ff.cond) inside {COND_START, COND_TRIP}) && (cond_o != $past(s_ff.cond))
      && (cond_o != COND_TRIP) && ($past(beh_mode_i) != BEH_OFF)
      |-> $past(s_ff.rel_cnt) == '0;
  endproperty
  a_release: assert property (p_release) else $error("release before delay");

  property p_remain;
    remain_o != '0 |-> cond_o == COND_START;
  endproperty
  a_remain: assert property (p_remain) else $error("countdown outside start");

  property p_expect;
    (ce_i && cfg_we_i) |=> expect_o == $past(cfg_op_dly_i);
  endproperty
  a_expect: assert property (p_expect) else $error("expected time not updated");

  property p_vis;
    (ce_i && !indiv_mode_en_i) |=> !beh_vis_o && (beh_o == BEH_ON);
  endproperty
  a_vis: assert property (p_vis) else $error("behaviour shown while disabled");

  property p_over;
    s_eval_on ##0 s_over_ch0 |=> cmp_o[0];
  endproperty
  a_over: assert property (p_over) else $error("greater-than not detected");

  property p_under_blk;
    s_eval_on ##0 (s_ff.mode[0] == CMP_UNDER && s_ff.scaled[0] < s_ff.blk_lim[0]) |=> !cmp_o[0];
  endproperty
  a_under_blk: assert property (p_under_blk) else $error("less-than not blocked");

endmodule : psc_stage

// ---- test/psc_stage_tb.sv ----
// Self-checking bench for the programmable stage comparator
`timescale 1ns/1ps
module psc_stage_tb;
  import psc_pkg::*;

  localparam int TICK = 8;
  localparam int OPN  = OP_DLY_MS / STEP_MS;
  localparam int RELN = REL_DLY_MS / STEP_MS;

  logic                   clk_i, reset_i, ce_i, cfg_we_i, block_i, indiv_mode_en_i;
  logic                   start_o, trip_o, blocked_o, beh_vis_o;
  logic [NCH-1:0]         cfg_sel_i, cmp_o, held_e, a_sel;
  logic [NCH-1:0][DW-1:0] cfg_hyst_i, a_hyst;
  logic [TW-1:0]          cfg_op_dly_i, cfg_rel_dly_i, remain_o, expect_o;
  psc_word_t [NCH-1:0]    meas_i, cfg_mult_i, cfg_level_i, cfg_blk_lim_i, scaled_o;
  psc_word_t [NCH-1:0]    a_mult, a_lvl, a_blk;
  psc_ratio_t [NCH-1:0]   ratio_o;
  psc_cmp_t [NCH-1:0]     cfg_mode_i, a_mode;
  psc_cond_t              cond_o;
  psc_beh_t               beh_mode_i, beh_o;
  int                     failures, n_checks, seed;

  psc_stage #(.TICK_CYC(TICK)) u_psc_stage (
    .clk_i, .reset_i, .ce_i, .meas_i, .cfg_we_i, .cfg_sel_i, .cfg_mult_i, .cfg_mode_i,
    .cfg_level_i, .cfg_hyst_i, .cfg_blk_lim_i, .cfg_op_dly_i, .cfg_rel_dly_i, .block_i,
    .beh_mode_i, .indiv_mode_en_i, .scaled_o, .ratio_o, .cmp_o, .cond_o, .start_o,
    .trip_o, .blocked_o, .remain_o, .expect_o, .beh_o, .beh_vis_o
  );

  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR at %0t ns: seen %0h, expected %0h", $time, seen, exp);
    end
  endtask : chk

  task automatic print_verdict();
    $display("checks %0d, failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : print_verdict

  // Tick edge plus both processing phases; ends where step results are settled
  task automatic step();
    repeat (3) @(posedge clk_i);
    #1;
  endtask : step

  // Rest of the step; a settings load lands on a non-tick edge
  task automatic tail(input bit ld);
    cfg_we_i = ld;
    @(posedge clk_i);
    #1;
    cfg_we_i = 1'b0;
    repeat (4) @(posedge clk_i);
    #1;
  endtask : tail

  task automatic idle(input int n);
    repeat (n) begin
      step();
      tail(1'b0);
    end
  endtask : idle

  // Pick-up from normal, countdown, then trip after op steps
  task automatic run_trip(input int op);
    meas_i[0] = 32'sh0000_0065;
    for (int j = 0; j <= op; j++) begin
      step();
      chk(cond_o, (j == op) ? COND_TRIP : COND_START);
      chk(remain_o, TW'(op - j));
      chk(trip_o, j == op);
      if (j < op) chk(start_o, 1'b1);
      tail(1'b0);
    end
  endtask : run_trip

  function automatic psc_word_t f_scl(psc_word_t m, psc_word_t k);
    longint p;
    p = longint'(m) * longint'(k);
    return psc_word_t'(p >>> MULT_FRAC);
  endfunction : f_scl

  // Static comparator with hysteresis band once held
  function automatic logic f_cmp(psc_cmp_t md, longint x, longint l, longint h, longint b,
                                 logic held);
    longint band;
    longint a;
    band = ((l < 0) ? -l : l) * h / PCT_DEN;
    a = (x < 0) ? -x : x;
    case (md)
      CMP_OVER:     return held ? (x > l - band) : (x > l);
      CMP_OVER_ABS: return held ? (a > l - band) : (a > l);
      CMP_UNDER:    return (x >= b) && (held ? (x < l + band) : (x < l));
      default:      return (x >= b) && (held ? (a < l + band) : (a < l));
    endcase
  endfunction : f_cmp

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20000) @(posedge clk_i);
    failures++;
    print_verdict();
  end

  initial begin
    logic e;
    seed = 51;
    failures = 0;
    n_checks = 0;
    {reset_i, ce_i, cfg_we_i, block_i, indiv_mode_en_i} = 5'b11000;
    beh_mode_i = BEH_ON;
    cfg_sel_i = 4'h1;
    cfg_op_dly_i = OP_DLY_RST;
    cfg_rel_dly_i = REL_DLY_RST;
    meas_i = '0;
    for (int k = 0; k < NCH; k++) begin
      cfg_mult_i[k] = MULT_RST;
      cfg_mode_i[k] = CMP_OVER;
      cfg_level_i[k] = LEVEL_RST;
      cfg_hyst_i[k] = HYST_RST;
      cfg_blk_lim_i[k] = BLK_RST;
    end
    repeat (8) @(posedge clk_i);
    #1;
    chk(expect_o, TW'(OPN));
    chk({cond_o, start_o, trip_o, blocked_o, remain_o}, {COND_NORMAL, 22'h0});
    chk({beh_o, beh_vis_o, scaled_o[0]}, {BEH_ON, 33'h0});
    reset_i = 1'b0;
    // Defaults: channel 0, greater-than, level 0.01, 3 % band
    run_trip(OPN);
    meas_i[0] = 32'sh0000_0062;
    step();
    chk(cmp_o[0], 1'b1);
    tail(1'b0);
    meas_i[0] = 32'sh0000_0061;
    // Release falls RELN steps after the step in which pick-up drops
    for (int j = 1; j <= RELN + 1; j++) begin
      step();
      chk(cmp_o[0], 1'b0);
      chk(cond_o, (j == RELN + 1) ? COND_NORMAL : COND_TRIP);
      tail(1'b0);
    end
    // Block at pick-up, then block while started
    meas_i[0] = 32'sh0000_0065;
    block_i = 1'b1;
    step();
    chk({cond_o, blocked_o}, {COND_BLOCKED, 1'b1});
    block_i = 1'b0;
    tail(1'b0);
    step();
    chk(cond_o, COND_START);
    block_i = 1'b1;
    tail(1'b0);
    for (int j = 1; j <= RELN + 1; j++) begin
      step();
      chk(cond_o, (j == RELN + 1) ? COND_BLOCKED : COND_START);
      tail(1'b0);
    end
    meas_i[0] = '0;
    block_i = 1'b0;
    step();
    chk({cond_o, blocked_o}, {COND_NORMAL, 1'b0});
    cfg_op_dly_i = 19'h0_0003;
    cfg_rel_dly_i = '0;
    tail(1'b1);
    step();
    chk(expect_o, 19'h0_0003);
    tail(1'b0);
    run_trip(3);
    meas_i[0] = '0;
    step();
    chk(cond_o, COND_NORMAL);
    tail(1'b0);
    // Behaviour display, shown only when enabled
    for (int b = 0; b < 5; b++) begin
      for (int en = 0; en < 2; en++) begin
        beh_mode_i = psc_beh_t'(b);
        indiv_mode_en_i = en[0];
        step();
        chk(beh_o, en[0] ? psc_beh_t'(b) : BEH_ON);
        chk(beh_vis_o, en[0]);
        tail(1'b0);
      end
    end
    beh_mode_i = BEH_TEST_OFF;
    meas_i[0] = 32'sh0000_0065;
    step();
    chk({cond_o, start_o}, {COND_START, 1'b0});
    beh_mode_i = BEH_OFF;
    tail(1'b0);
    step();
    chk({cond_o, cmp_o[0]}, {COND_NORMAL, 1'b0});
    beh_mode_i = BEH_ON;
    meas_i[0] = '0;
    tail(1'b0);
    // Change modes: step of 60 on 1000 against a threshold of 50
    for (int m = 4; m < 8; m++) begin
      for (int j = 0; j < 4; j++) begin
        cfg_mode_i[0] = psc_cmp_t'(m);
        cfg_level_i[0] = psc_word_t'((j[0] ? -1 : 1) * ((m < 6) ? 50000 : 50));
        cfg_hyst_i[0] = '0;
        meas_i[0] = 32'sh0000_03E8;
        step();
        tail(1'b1);
        idle(5);
        meas_i[0] = j[1] ? 32'sh0000_03AC : 32'sh0000_0424;
        step();
        chk(cmp_o[0], m[0] || (j[0] == j[1]));
        tail(1'b0);
      end
    end
    // Random settings per channel, reloaded every step
    for (int k = 0; k < NCH; k++) begin
      {cfg_mode_i[k], cfg_level_i[k], cfg_hyst_i[k]} = {CMP_OVER, LEVEL_RST, HYST_RST};
    end
    meas_i = '0;
    step();
    tail(1'b1);
    idle(1);
    held_e = '0;
    for (int j = 0; j < 80; j++) begin
      {a_mult, a_mode, a_lvl, a_hyst, a_blk} =
        {cfg_mult_i, cfg_mode_i, cfg_level_i, cfg_hyst_i, cfg_blk_lim_i};
      a_sel = cfg_sel_i;
      for (int k = 0; k < NCH; k++) begin
        cfg_mode_i[k] = psc_cmp_t'($random(seed) & 3);
        cfg_level_i[k] = $random(seed) % 3000;
        cfg_hyst_i[k] = $unsigned($random(seed)) % 500001;
        cfg_blk_lim_i[k] = $random(seed) % 2000;
        cfg_mult_i[k] = 32'h0000_8000 + ($random(seed) & 32'h0001_FFFF);
        meas_i[k] = $random(seed) % 2000;
      end
      cfg_sel_i = 4'($random(seed));
      block_i = 1'($random(seed));
      indiv_mode_en_i = 1'($random(seed));
      step();
      for (int k = 0; k < NCH; k++) begin
        chk(scaled_o[k], f_scl(meas_i[k], a_mult[k]));
        // Unselected channels hold nothing, so their next threshold is the plain one
        e = a_sel[k] && f_cmp(a_mode[k], f_scl(meas_i[k], a_mult[k]), a_lvl[k], a_hyst[k],
                              a_blk[k], held_e[k]);
        chk(cmp_o[k], e);
        held_e[k] = e;
      end
      tail(1'b1);
    end
    // Ratios settle through the shared divider; channel 3 negative
    cfg_sel_i = '0;
    block_i = 1'b0;
    for (int k = 0; k < NCH; k++) begin
      {cfg_mult_i[k], cfg_mode_i[k], cfg_level_i[k]} = {MULT_RST, CMP_OVER, LEVEL_RST};
      meas_i[k] = psc_word_t'((k == 3) ? -300 : 100 * (k + 1));
    end
    step();
    tail(1'b1);
    // A full divider round after the new samples is 250 cycles at worst
    idle(33);
    for (int k = 0; k < NCH; k++) begin
      chk(ratio_o[k], psc_ratio_t'(longint'(meas_i[k]) * UNIT / longint'(LEVEL_RST)));
    end
    // Clock enable low freezes cadence, samples and the divider
    ce_i = 1'b0;
    meas_i[0] = 32'sh0000_0190;
    idle(2);
    chk(scaled_o[0], 32'sh0000_0064);
    chk(ratio_o[0], 48'sh0000_0000_2710);
    print_verdict();
  end
endmodule : psc_stage_tb
